// ### inc/rfb_pkg.sv
package rfb_pkg;
    localparam logic [7:0]  RFB_DEPTH     = 8'h80;
    localparam logic [31:0] RFB_CHIP_BASE = 32'hd9c3522e;
    localparam logic [31:0] RFB_ODD_MASK  = 32'h55555555;
    localparam logic [7:0]  RFB_SFD       = 8'ha7;
    localparam logic [2:0]  RFB_PRE_BYTES = 3'h4;
    localparam logic [5:0]  RFB_MAX_DIST  = 6'h06;
    localparam logic [6:0]  RFB_CORR_FULL = 7'h40;
    localparam logic [15:0] RFB_CRC_INIT  = 16'h0000;
    localparam logic [15:0] RFB_CRC_POLY  = 16'h8408;
    localparam logic [7:0]  RFB_AGC_HI    = 8'h60;
    localparam logic [7:0]  RFB_AGC_LO    = 8'h20;
    localparam logic [7:0]  RFB_CCA_THR   = 8'h30;
    localparam logic [3:0]  RFB_GAIN_MAX  = 4'hf;
    localparam logic [3:0]  RFB_GAIN_RST  = 4'h8;
    localparam logic [3:0]  RFB_AGC_LAST  = 4'hf;

    typedef struct packed {
        logic       valid;
        logic [7:0] sample;
    } rfb_smp_t;

    typedef struct packed {
        logic valid;
        logic chip;
    } rfb_chip_t;

    typedef enum logic [4:0] {
        RFB_RX_HUNT = 5'b00001,
        RFB_RX_LEN  = 5'b00010,
        RFB_RX_DATA = 5'b00100,
        RFB_RX_TRL1 = 5'b01000,
        RFB_RX_TRL2 = 5'b10000
    } rfb_rx_st_t;

    typedef enum logic [2:0] {
        RFB_TX_IDLE = 3'b001,
        RFB_TX_SHR  = 3'b010,
        RFB_TX_DATA = 3'b100
    } rfb_tx_st_t;

    // chip c0 sits in bit 31 and goes out first
    function automatic logic [31:0] rfb_spread(input logic [3:0] sym);
        logic [63:0] x;
        x = {RFB_CHIP_BASE, RFB_CHIP_BASE} >> {sym[2:0], 2'b00};
        return x[31:0] ^ (sym[3] ? RFB_ODD_MASK : 32'h00000000);
    endfunction

    // returns {hamming distance, best symbol}
    function automatic logic [9:0] rfb_despread(input logic [31:0] win);
        logic [5:0] d;
        logic [9:0] best;
        best = {6'h3f, 4'h0};
        for (int s = 0; s < 16; s++) begin
            d = 6'($countones(win ^ rfb_spread(4'(s))));
            if (d < best[9:4]) best = {d, 4'(s)};
        end
        return best;
    endfunction

    function automatic logic [15:0] rfb_crc8(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++) r = (r[0] ^ b[i]) ? ((r >> 1) ^ RFB_CRC_POLY) : (r >> 1);
        return r;
    endfunction
endpackage

// ### src/rfb_top.sv
`timescale 1ns/100ps
module rfb_top import rfb_pkg::*; (
    input  wire logic      clock,
    input  wire logic      arst_n,
    input  wire logic      rx_en,
    input  wire rfb_smp_t  rx_smp,
    output logic [3:0]     agc_gain,
    output logic [7:0]     rssi,
    output logic           cca,
    output logic           irq_sfd,
    output logic           irq_cca,
    input  wire logic      rx_rd,
    output logic [7:0]     rx_rd_data,
    output logic           rx_empty,
    output logic [7:0]     rx_count,
    output logic           rx_overflow,
    input  wire logic      tx_wr,
    input  wire logic [7:0] tx_wr_data,
    output logic           tx_full,
    output logic [7:0]     tx_count,
    input  wire logic      tx_start,
    output logic           tx_busy,
    input  wire logic      tx_chip_req,
    output rfb_chip_t      tx_dac
);
    //--------------------------------------------------
    // front end
    //--------------------------------------------------
    logic signed [7:0] smp_s, prev_q, prev_d;
    logic signed [8:0] filt;
    logic [7:0]        mag, rssi_q, rssi_d;
    logic [3:0]        gain_q, gain_d, agc_cnt_q, agc_cnt_d;
    logic              cca_q, cca_d, irq_cca_q, irq_cca_d, chip_v, chip;

    assign chip_v = rx_smp.valid;
    assign smp_s  = signed'(rx_smp.sample);

    always_comb begin
        filt      = ($signed({smp_s[7], smp_s}) + $signed({prev_q[7], prev_q})) >>> 1;
        mag       = filt[8] ? 8'(-filt) : filt[7:0];
        chip      = ~filt[8];
        prev_d    = prev_q;
        rssi_d    = rssi_q;
        gain_d    = gain_q;
        agc_cnt_d = agc_cnt_q;
        if (chip_v) begin
            prev_d    = smp_s;
            rssi_d    = rssi_q - (rssi_q >> 3) + (mag >> 3);
            agc_cnt_d = agc_cnt_q + 4'h1;
            // stepping only once per window keeps the loop from hunting
            if (agc_cnt_q == RFB_AGC_LAST) begin
                if (mag > RFB_AGC_HI && gain_q != 4'h0) gain_d = gain_q - 4'h1;
                else if (mag < RFB_AGC_LO && gain_q != RFB_GAIN_MAX) gain_d = gain_q + 4'h1;
            end
        end
        cca_d     = rssi_q < RFB_CCA_THR;
        irq_cca_d = rx_en && (cca_d != cca_q);
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            prev_q    <= 8'sh00;
            rssi_q    <= 8'h00;
            gain_q    <= RFB_GAIN_RST;
            agc_cnt_q <= 4'h0;
            cca_q     <= 1'b0;
            irq_cca_q <= 1'b0;
        end else begin
            prev_q    <= prev_d;
            rssi_q    <= rssi_d;
            gain_q    <= gain_d;
            agc_cnt_q <= agc_cnt_d;
            cca_q     <= cca_d;
            irq_cca_q <= irq_cca_d;
        end
    end

    //--------------------------------------------------
    // receive framer
    //--------------------------------------------------
    rfb_rx_st_t  rx_st_q, rx_st_d;
    logic [63:0] win_q, win_d, win_n;
    logic [9:0]  dec_hi, dec_lo;
    logic [4:0]  cc_q, cc_d;
    logic        rh_q, rh_d, sym_end, sfd_q, sfd_d, rw_en;
    logic [3:0]  nib_q, nib_d;
    logic [6:0]  rrem_q, rrem_d, corr_q, corr_d;
    logic [15:0] crc_q, crc_d;
    logic [7:0]  rw_data, rbyte;

    assign win_n   = {win_q[62:0], chip};
    assign dec_hi  = rfb_despread(win_n[63:32]);
    assign dec_lo  = rfb_despread(win_n[31:0]);
    assign sym_end = chip_v && (cc_q == 5'h1f);
    assign rbyte   = {dec_lo[3:0], nib_q};

    always_comb begin
        rx_st_d = rx_st_q;
        win_d   = win_q;
        cc_d    = cc_q;
        rh_d    = rh_q;
        nib_d   = nib_q;
        rrem_d  = rrem_q;
        crc_d   = crc_q;
        corr_d  = corr_q;
        sfd_d   = 1'b0;
        rw_en   = 1'b0;
        rw_data = 8'h00;
        if (chip_v) begin
            win_d = win_n;
            cc_d  = cc_q + 5'h01;
        end
        unique case (rx_st_q)
            RFB_RX_HUNT: begin
                if (chip_v && rx_en && dec_hi[3:0] == RFB_SFD[3:0] && dec_lo[3:0] == RFB_SFD[7:4]
                    && dec_hi[9:4] <= RFB_MAX_DIST && dec_lo[9:4] <= RFB_MAX_DIST) begin
                    sfd_d   = 1'b1;
                    rx_st_d = RFB_RX_LEN;
                    cc_d    = 5'h00;
                    rh_d    = 1'b0;
                    crc_d   = RFB_CRC_INIT;
                    corr_d  = 7'(RFB_CORR_FULL - 7'(dec_hi[9:4]) - 7'(dec_lo[9:4]));
                end
            end
            RFB_RX_LEN, RFB_RX_DATA: begin
                if (sym_end) begin
                    rh_d  = ~rh_q;
                    nib_d = dec_lo[3:0];
                    if (rh_q) begin
                        rw_en   = 1'b1;
                        rw_data = rbyte;
                        if (rx_st_q == RFB_RX_LEN) begin
                            rrem_d  = rbyte[6:0];
                            rx_st_d = (rbyte[6:0] == 7'h00) ? RFB_RX_TRL1 : RFB_RX_DATA;
                        end else begin
                            crc_d  = rfb_crc8(crc_q, rbyte);
                            rrem_d = rrem_q - 7'h01;
                            if (rrem_q == 7'h01) rx_st_d = RFB_RX_TRL1;
                        end
                    end
                end
                if (!rx_en) rx_st_d = RFB_RX_HUNT;
            end
            RFB_RX_TRL1: begin
                rw_en   = 1'b1;
                rw_data = rssi_q;
                rx_st_d = RFB_RX_TRL2;
            end
            RFB_RX_TRL2: begin
                rw_en   = 1'b1;
                rw_data = {crc_q == 16'h0000, corr_q};
                rx_st_d = RFB_RX_HUNT;
            end
            default: rx_st_d = RFB_RX_HUNT;
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rx_st_q <= RFB_RX_HUNT;
            win_q   <= 64'h0;
            cc_q    <= 5'h00;
            rh_q    <= 1'b0;
            nib_q   <= 4'h0;
            rrem_q  <= 7'h00;
            crc_q   <= RFB_CRC_INIT;
            corr_q  <= 7'h00;
            sfd_q   <= 1'b0;
        end else begin
            rx_st_q <= rx_st_d;
            win_q   <= win_d;
            cc_q    <= cc_d;
            rh_q    <= rh_d;
            nib_q   <= nib_d;
            rrem_q  <= rrem_d;
            crc_q   <= crc_d;
            corr_q  <= corr_d;
            sfd_q   <= sfd_d;
        end
    end

    //--------------------------------------------------
    // fifos
    //--------------------------------------------------
    logic [7:0] rx_mem [128];
    logic [7:0] tx_mem [128];
    logic [6:0] rwp_q, rwp_d, rrp_q, rrp_d, twp_q, twp_d, trp_q, trp_d;
    logic [7:0] rcnt_q, rcnt_d, tcnt_q, tcnt_d, rdat_q, rdat_d, rx_head, tx_head;
    logic       rx_push, rx_pop, tx_push, tx_pop, ovf_q, ovf_d;

    assign rx_head = rx_mem[rrp_q];
    assign tx_head = tx_mem[trp_q];

    always_comb begin
        // a full fifo drops new bytes even if a pop lands the same cycle
        rx_push = rw_en && (rcnt_q != RFB_DEPTH);
        rx_pop  = rx_rd && (rcnt_q != 8'h00);
        tx_push = tx_wr && (tcnt_q != RFB_DEPTH);
        rwp_d   = rwp_q + {6'h00, rx_push};
        rrp_d   = rrp_q + {6'h00, rx_pop};
        rcnt_d  = rcnt_q + {7'h00, rx_push} - {7'h00, rx_pop};
        rdat_d  = rx_pop ? rx_head : rdat_q;
        ovf_d   = (rw_en && !rx_push) || (ovf_q && rx_en);
        twp_d   = twp_q + {6'h00, tx_push};
        trp_d   = trp_q + {6'h00, tx_pop};
        tcnt_d  = tcnt_q + {7'h00, tx_push} - {7'h00, tx_pop};
    end

    always_ff @(posedge clock) begin
        if (rx_push) rx_mem[rwp_q] <= rw_data;
        if (tx_push) tx_mem[twp_q] <= tx_wr_data;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rwp_q  <= 7'h00;
            rrp_q  <= 7'h00;
            rcnt_q <= 8'h00;
            rdat_q <= 8'h00;
            ovf_q  <= 1'b0;
            twp_q  <= 7'h00;
            trp_q  <= 7'h00;
            tcnt_q <= 8'h00;
        end else begin
            rwp_q  <= rwp_d;
            rrp_q  <= rrp_d;
            rcnt_q <= rcnt_d;
            rdat_q <= rdat_d;
            ovf_q  <= ovf_d;
            twp_q  <= twp_d;
            trp_q  <= trp_d;
            tcnt_q <= tcnt_d;
        end
    end

    //--------------------------------------------------
    // transmit engine
    //--------------------------------------------------
    rfb_tx_st_t tx_st_q, tx_st_d;
    logic [4:0] idx_q, idx_d;
    logic       th_q, th_d, tx_go, tbyte_end;
    logic [7:0] cur_q, cur_d;
    logic [2:0] bcnt_q, bcnt_d;
    logic [6:0] trem_q, trem_d;
    logic [31:0] chips;
    rfb_chip_t  dac_q, dac_d;

    assign tx_go     = tx_chip_req && (tx_st_q != RFB_TX_IDLE);
    assign tbyte_end = tx_go && (idx_q == 5'h1f) && th_q;

    always_comb begin
        tx_st_d = tx_st_q;
        idx_d   = idx_q;
        th_d    = th_q;
        cur_d   = cur_q;
        bcnt_d  = bcnt_q;
        trem_d  = trem_q;
        tx_pop  = 1'b0;
        chips      = rfb_spread(th_q ? cur_q[7:4] : cur_q[3:0]);
        dac_d.valid = tx_go;
        dac_d.chip  = tx_go & chips[~idx_q];
        if (tx_go) begin
            idx_d = idx_q + 5'h01;
            if (idx_q == 5'h1f) th_d = ~th_q;
        end
        unique case (tx_st_q)
            RFB_TX_IDLE: begin
                if (tx_start && tcnt_q != 8'h00) begin
                    tx_st_d = RFB_TX_SHR;
                    cur_d   = 8'h00;
                    bcnt_d  = 3'h0;
                    idx_d   = 5'h00;
                    th_d    = 1'b0;
                end
            end
            RFB_TX_SHR: begin
                if (tbyte_end) begin
                    if (bcnt_q == RFB_PRE_BYTES) begin
                        tx_pop  = tcnt_q != 8'h00;
                        cur_d   = tx_head;
                        trem_d  = tx_head[6:0];
                        tx_st_d = tx_pop ? RFB_TX_DATA : RFB_TX_IDLE;
                    end else begin
                        bcnt_d = bcnt_q + 3'h1;
                        if (bcnt_q == RFB_PRE_BYTES - 3'h1) cur_d = RFB_SFD;
                    end
                end
            end
            RFB_TX_DATA: begin
                if (tbyte_end) begin
                    // an empty fifo mid frame ends the frame short
                    if (trem_q == 7'h00 || tcnt_q == 8'h00) begin
                        tx_st_d = RFB_TX_IDLE;
                    end else begin
                        tx_pop = 1'b1;
                        cur_d  = tx_head;
                        trem_d = trem_q - 7'h01;
                    end
                end
            end
            default: tx_st_d = RFB_TX_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tx_st_q <= RFB_TX_IDLE;
            idx_q   <= 5'h00;
            th_q    <= 1'b0;
            cur_q   <= 8'h00;
            bcnt_q  <= 3'h0;
            trem_q  <= 7'h00;
            dac_q   <= '0;
        end else begin
            tx_st_q <= tx_st_d;
            idx_q   <= idx_d;
            th_q    <= th_d;
            cur_q   <= cur_d;
            bcnt_q  <= bcnt_d;
            trem_q  <= trem_d;
            dac_q   <= dac_d;
        end
    end

    assign agc_gain    = gain_q;
    assign rssi        = rssi_q;
    assign cca         = cca_q;
    assign irq_sfd     = sfd_q;
    assign irq_cca     = irq_cca_q;
    assign rx_rd_data  = rdat_q;
    assign rx_empty    = rcnt_q == 8'h00;
    assign rx_count    = rcnt_q;
    assign rx_overflow = ovf_q;
    assign tx_full     = tcnt_q == RFB_DEPTH;
    assign tx_count    = tcnt_q;
    assign tx_busy     = tx_st_q != RFB_TX_IDLE;
    assign tx_dac      = dac_q;

    //--------------------------------------------------
    // assertions
    //--------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    property p_sfd_irq;
        irq_sfd |-> rx_st_q == RFB_RX_LEN && $past(rx_st_q) == RFB_RX_HUNT ##1 !irq_sfd;
    endproperty
    a_sfd_irq: assert property (p_sfd_irq) else $error("sfd irq wrong");

    property p_rx_cap;
        rcnt_q <= RFB_DEPTH && !(rcnt_q == RFB_DEPTH && rx_push);
    endproperty
    a_rx_cap: assert property (p_rx_cap) else $error("rx fifo over capacity");

    property p_rx_pop;
        rx_rd && !rx_empty && !rx_push |=> rcnt_q == $past(rcnt_q) - 8'h01 && rx_rd_data == $past(rx_head);
    endproperty
    a_rx_pop: assert property (p_rx_pop) else $error("rx pop wrong");

    property p_crc_flag;
        // a full fifo may drop the trailer, which rx_overflow reports
        rx_st_q == RFB_RX_TRL2 |-> (rx_push || rcnt_q == RFB_DEPTH) && rw_data[7] == (crc_q == 16'h0000)
            ##1 rx_st_q == RFB_RX_HUNT;
    endproperty
    a_crc_flag: assert property (p_crc_flag) else $error("crc flag wrong");

    property p_trailer;
        rx_st_q == RFB_RX_DATA && rrem_q == 7'h01 && sym_end && rh_q && rx_en
            |=> rx_st_q == RFB_RX_TRL1 && rw_data == rssi_q ##1 rx_st_q == RFB_RX_TRL2;
    endproperty
    a_trailer: assert property (p_trailer) else $error("trailer missing");

    property p_cca_irq;
        irq_cca |-> $past(rx_en) && cca != $past(cca);
    endproperty
    a_cca_irq: assert property (p_cca_irq) else $error("cca irq wrong");

    property p_tx_push;
        tx_wr && !tx_full && !tx_pop |=> tcnt_q == $past(tcnt_q) + 8'h01;
    endproperty
    a_tx_push: assert property (p_tx_push) else $error("tx push lost");

    property p_shr;
        tx_st_q == RFB_TX_IDLE && tx_start && tcnt_q != 8'h00 |=> tx_st_q == RFB_TX_SHR && cur_q == 8'h00;
    endproperty
    a_shr: assert property (p_shr) else $error("no preamble");

    property p_pre_chip;
        tx_go && tx_st_q == RFB_TX_SHR && bcnt_q < RFB_PRE_BYTES - 3'h1
            |=> tx_dac.valid && tx_dac.chip == RFB_CHIP_BASE[5'h1f - $past(idx_q)];
    endproperty
    a_pre_chip: assert property (p_pre_chip) else $error("preamble chip wrong");

    property p_agc_step;
        gain_q == $past(gain_q) || gain_q == $past(gain_q) + 4'h1 || gain_q == $past(gain_q) - 4'h1;
    endproperty
    a_agc_step: assert property (p_agc_step) else $error("gain jumped");

    c_sfd:   cover property (irq_sfd);
    c_frame: cover property (rx_st_q == RFB_RX_TRL2 && crc_q == 16'h0000);
    c_txend: cover property (tx_st_q == RFB_TX_DATA ##1 tx_st_q == RFB_TX_IDLE);
endmodule // rfb_top

// ### testbench/rfb_radio_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// radio side: dac chip requests and looped back samples
// ----------------------------------------
module rfb_radio_model import rfb_pkg::*; (
    input  wire logic       clock,
    input  wire logic       arst_n,
    input  wire logic       slow,
    input  wire logic [1:0] noise,
    input  wire logic       tx_busy,
    input  wire rfb_chip_t  tx_dac,
    output logic            tx_chip_req,
    output rfb_smp_t        rx_smp
);
    logic [6:0] mag_q;
    logic       last_q;
    logic [7:0] junk_q;
    logic [6:0] mag_d;

    // sign flips grow in size so the two-tap average keeps the new sign
    always_comb begin
        mag_d = 7'h0a;
        if (tx_dac.chip != last_q) mag_d = (mag_q > 7'h75) ? 7'h7f : mag_q + 7'h0a;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            mag_q       <= 7'h0a;
            last_q      <= 1'b0;
            junk_q      <= 8'h00;
            tx_chip_req <= 1'b0;
            rx_smp      <= '0;
        end else begin
            junk_q      <= junk_q + 8'h35;
            tx_chip_req <= tx_busy && !(slow && tx_chip_req);
            if (tx_dac.valid) begin
                mag_q  <= mag_d;
                last_q <= tx_dac.chip;
                rx_smp <= {1'b1, tx_dac.chip ? {1'b0, mag_d} : 8'h00 - {1'b0, mag_d}};
            end else if (noise != 2'h0) begin
                rx_smp <= {1'b1, noise[0] ? 8'h70 : 8'h00};
            end else begin
                // idle line shows a moving pattern, not the last sample
                rx_smp <= {1'b0, junk_q};
            end
        end
    end
endmodule // rfb_radio_model

// ### testbench/rfb_top_tb.sv
`timescale 1ns/100ps
module rfb_top_tb import rfb_pkg::*; ;
    logic        clock = 1'b0;
    logic        arst_n = 1'b0;
    logic        rx_en = 1'b0;
    logic        rx_rd = 1'b0;
    logic        tx_wr = 1'b0;
    logic        tx_start = 1'b0;
    logic        slow = 1'b0;
    logic [7:0]  tx_wr_data = 8'h00;
    logic [1:0]  noise = 2'h0;
    rfb_smp_t    rx_smp;
    rfb_chip_t   tx_dac;
    logic        tx_chip_req, cca, irq_sfd, irq_cca, rx_empty, rx_overflow, tx_full, tx_busy;
    logic [3:0]  agc_gain;
    logic [7:0]  rssi, rx_rd_data, rx_count, tx_count;
    logic        rd_q = 1'b0;
    logic [8:0]  e;
    logic [31:0] seed = 32'h00012cfb;
    int          failures = 0, checks_done = 0, sfd_n = 0, cca_n = 0;
    logic        exp_chip[$];
    logic [8:0]  exp_rx[$];

    always #5 clock = ~clock;

    rfb_top dut (.clock(clock), .arst_n(arst_n), .rx_en(rx_en), .rx_smp(rx_smp), .agc_gain(agc_gain),
        .rssi(rssi), .cca(cca), .irq_sfd(irq_sfd), .irq_cca(irq_cca), .rx_rd(rx_rd), .rx_rd_data(rx_rd_data),
        .rx_empty(rx_empty), .rx_count(rx_count), .rx_overflow(rx_overflow), .tx_wr(tx_wr),
        .tx_wr_data(tx_wr_data), .tx_full(tx_full), .tx_count(tx_count), .tx_start(tx_start),
        .tx_busy(tx_busy), .tx_chip_req(tx_chip_req), .tx_dac(tx_dac));
    rfb_radio_model radio (.clock(clock), .arst_n(arst_n), .slow(slow), .noise(noise), .tx_busy(tx_busy),
        .tx_dac(tx_dac), .tx_chip_req(tx_chip_req), .rx_smp(rx_smp));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [31:0] sp(input logic [3:0] s);
        logic [31:0] v;
        v = RFB_CHIP_BASE;
        for (int i = 0; i < s[2:0]; i++) v = {v[3:0], v[31:4]};
        return s[3] ? v ^ RFB_ODD_MASK : v;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic note_byte(input logic [7:0] b);
        logic [31:0] c;
        for (int h = 0; h < 2; h++) begin
            c = sp(h ? b[7:4] : b[3:0]);
            for (int i = 31; i >= 0; i--) exp_chip.push_back(c[i]);
        end
    endtask

    // load length, n random bytes and fcs; note chips and fifo contents
    task automatic frame(input int n, input logic good);
        logic [7:0]  d[$];
        logic [15:0] c;
        logic [7:0]  b;
        c = 16'h0000;
        for (int i = 0; i < n; i++) begin
            b = 8'(xs());
            d.push_back(b);
            for (int k = 0; k < 8; k++) c = (c[0] ^ b[k]) ? (c >> 1) ^ RFB_CRC_POLY : c >> 1;
        end
        d.push_back(good ? c[7:0] : ~c[7:0]);
        d.push_back(c[15:8]);
        d.push_front(8'(d.size()));
        repeat (4) note_byte(8'h00);
        note_byte(RFB_SFD);
        foreach (d[i]) note_byte(d[i]);
        foreach (d[i]) exp_rx.push_back({1'b1, d[i]});
        exp_rx.push_back(9'h000);
        exp_rx.push_back({1'b1, good, RFB_CORR_FULL[6:0]});
        foreach (d[i]) begin
            tx_wr      <= 1'b1;
            tx_wr_data <= d[i];
            @(posedge clock);
        end
        tx_wr <= 1'b0;
    endtask

    task automatic run(input int n);
        tx_start <= 1'b1;
        @(posedge clock);
        tx_start <= 1'b0;
        @(posedge clock);
        #1 chk(tx_busy, 1, "busy after start");
        for (int i = 0; i < 40000 && tx_busy !== 1'b0; i++) @(posedge clock);
        // let the watcher take the last chip first
        #1 chk(exp_chip.size(), 0, "chips left over");
        for (int i = 0; i < 300 && rx_count !== 8'(n); i++) @(posedge clock);
        // trailer bytes and the overflow flag land a few cycles later
        repeat (2) @(posedge clock);
        #1 chk(rx_count, n, "rx fifo level");
        @(posedge clock);
    endtask

    // drained back to back, as a dma engine would
    task automatic pop_all(input int n);
        rx_rd <= 1'b1;
        repeat (n) @(posedge clock);
        rx_rd <= 1'b0;
        repeat (2) @(posedge clock);
        chk(exp_rx.size(), 0, "bytes not popped");
    endtask

    // ----------------------------------------
    // output watcher
    // ----------------------------------------
    always @(posedge clock) begin
        if (rd_q) begin
            if (exp_rx.size() == 0) chk(1, 0, "extra rx byte");
            else begin
                e = exp_rx.pop_front();
                if (e[8]) chk(rx_rd_data, e[7:0], "rx byte");
            end
        end
        rd_q <= rx_rd && !rx_empty;
        if (tx_dac.valid === 1'b1) begin
            if (exp_chip.size() == 0) chk(1, 0, "extra chip");
            else chk(tx_dac.chip, exp_chip.pop_front(), "chip");
        end
        if (irq_sfd === 1'b1) sfd_n++;
        if (irq_cca === 1'b1) cca_n++;
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge clock);
        arst_n <= 1'b1;
        rx_en  <= 1'b1;
        @(posedge clock);
        #1 chk(agc_gain, 4'h8, "gain at reset");
        chk(rx_empty, 1, "rx empty at reset");
        chk(tx_count, 0, "tx empty at reset");
        @(posedge clock);
        tx_start <= 1'b1;
        @(posedge clock);
        tx_start <= 1'b0;
        @(posedge clock);
        #1 chk(tx_busy, 0, "start with empty fifo");
        $display("test reset done");
        @(posedge clock);
        sfd_n = 0;
        frame(3, 1);
        run(8);
        chk(sfd_n, 1, "delimiter interrupt");
        pop_all(8);
        $display("test good frame done");
        frame(1, 0);
        run(6);
        pop_all(6);
        $display("test bad crc frame done");
        noise <= 2'h2;
        repeat (100) @(posedge clock);
        cca_n = 0;
        noise <= 2'h1;
        repeat (300) @(posedge clock);
        #1 chk(cca, 0, "busy channel");
        chk(rssi >= 8'h70 && rssi <= 8'h77, 1, "strength on busy channel");
        chk(agc_gain < 4'h8, 1, "gain stepped down");
        @(posedge clock);
        noise <= 2'h2;
        repeat (100) @(posedge clock);
        #1 chk(cca, 1, "clear channel");
        chk(rssi <= 8'h07, 1, "strength on clear channel");
        chk(cca_n, 2, "channel interrupts");
        @(posedge clock);
        noise <= 2'h0;
        $display("test channel assessment done");
        slow <= 1'b1;
        frame(125, 1);
        @(posedge clock);
        tx_wr      <= 1'b1;
        tx_wr_data <= 8'(xs());
        @(posedge clock);
        tx_wr <= 1'b0;
        @(posedge clock);
        #1 chk(tx_count, 128, "tx fifo capacity");
        chk(tx_full, 1, "tx full");
        @(posedge clock);
        run(128);
        chk(rx_overflow, 1, "rx overflow");
        exp_rx.delete();
        rx_en <= 1'b0;
        repeat (2) @(posedge clock);
        #1 chk(rx_overflow, 0, "overflow cleared");
        $display("test full fifos done");
        tally_and_finish();
    end

    initial begin
        #600000;
        failures++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        tally_and_finish();
    end
endmodule // rfb_top_tb
